// File: core/tac_top.v
// Function
// [R1] Any selection write starts the chosen acquisition; a write of code 11 sends the sequencer to idle instead
// [R2] Selection register reads back last written code
// [R3] Count word: count, X index, Y index
// [R4] Self groups: Y zero, pair index rising
// [R5] Matrix: Y steps within X, then X
// [R6] Four burst fields, one repeat per unit
// [R7] Host writes all Y bursts per line
// [R8] Burst request flag high while awaiting bursts
// [R9] Force bit keeps discharge source on
// [R10] Normal enable bit gates source during acquisition
// [R11] Bit 23 globally enables current module
// [R12] Bits 16, 17 pick resistor and reference
// [R13] Trim code sets discharge current monotonically
// [R14] Deviation field bounds spread burst stretch
// [R15] First-side pad bits select resistive drive
// [R16] Second-side pad bits select resistive drive
// [R17] Count-ready flag high while new word waits
// [R18] Bursts fill Y values ascending; flag clears
`timescale 1ns/1ps
`include "tac_consts.vh"

module tac_top #(
  parameter NPAIR = 32,
  parameter NY = 16
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  output reg irq_o,
  output reg fe_start_o,
  output reg fe_matrix_o,
  output reg [7:0] fe_x_o,
  output reg [7:0] fe_y_o,
  output reg [7:0] fe_burst_o,
  input wire fe_done_i,
  input wire [15:0] fe_count_i,
  output wire [7:0] src_en_o,
  output reg module_en_o,
  output reg ref_res_sel_o,
  output reg ref_volt_sel_o,
  output reg [4:0] trim_o,
  output reg [7:0] spread_dev_o,
  output reg [16:0] pad_a_res_o,
  output reg [16:0] pad_b_res_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_XFIND = 3'h1;
  localparam ST_BURST = 3'h2;
  localparam ST_YFIND = 3'h3;
  localparam ST_LAUNCH = 3'h4;
  localparam ST_WAIT_FE = 3'h5;
  localparam ST_WAIT_RD = 3'h6;
  localparam ST_DONE = 3'h7;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0] grp_a_reg;
  reg [31:0] grp_b_reg;
  reg [31:0] mtx_lines_reg;
  reg [1:0] sel_reg;
  reg [31:0] acquired_count_reg;
  reg [31:0] disch_reg;
  reg [7:0] dev_reg;
  reg ready_reg;
  reg breq_reg;
  reg [`TAC_IRQ_W-1:0] irq_sts_reg;
  reg [`TAC_IRQ_W-1:0] irq_mask_reg;
  reg [2:0] state_reg;
  reg [7:0] xcur_reg;
  reg [7:0] ycur_reg;
  reg [4:0] yord_reg;
  reg [4:0] fill_reg;
  reg [7:0] burst_mem [0:NY-1];
  reg [31:0] rd_mux;
  reg [31:0] wmask;
  reg [4:0] ny_cnt;
  reg [`TAC_IRQ_W-1:0] irq_sts_next;
  integer i;
  integer k;

  wire rd_acc = avs_read_i & ~avs_waitrequest_o;
  wire wr_acc = avs_write_i & ~avs_waitrequest_o;
  wire wr_sel = wr_acc & (avs_address_i == `TAC_OFS_ACQ_SEL);
  wire wr_matrix_burst_length = wr_acc & (avs_address_i == `TAC_OFS_MATRIX_BURST_LENGTH);
  wire rd_count = rd_acc & (avs_address_i == `TAC_OFS_ACQUIRED_COUNT);
  wire is_matrix = (sel_reg == `TAC_SEL_MATRIX);
  wire [15:0] x_mask = mtx_lines_reg[15:0];
  wire [15:0] y_mask = mtx_lines_reg[31:16];
  wire new_count = (state_reg == ST_WAIT_FE) & fe_done_i;
  wire acq_done = (state_reg == ST_DONE);
  wire breq_rise;
  reg [31:0] xa_mask;
  wire xa_found;
  wire [7:0] xa_idx;
  wire y_found;
  wire [7:0] y_idx;

  // ----------------------------------------------------------------
  // Channel search
  // ----------------------------------------------------------------
  always @* begin
    case (sel_reg)
      `TAC_SEL_SELF_B: xa_mask = grp_b_reg;
      `TAC_SEL_MATRIX: xa_mask = {16'h0000, x_mask};
      default: xa_mask = grp_a_reg;
    endcase
  end

  tac_chan_find #(.N(NPAIR)) u_find_x (
    .mask_i(xa_mask[NPAIR-1:0]),
    .from_i(xcur_reg),
    .found_o(xa_found),
    .idx_o(xa_idx)
  );

  tac_chan_find #(.N(NY)) u_find_y (
    .mask_i(y_mask[NY-1:0]),
    .from_i(ycur_reg),
    .found_o(y_found),
    .idx_o(y_idx)
  );

  always @* begin
    ny_cnt = 5'h00;
    for (i = 0; i < NY; i = i + 1) begin
      ny_cnt = ny_cnt + {4'h0, y_mask[i]};
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  always @* begin
    wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
             {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address_i)
      `TAC_OFS_GRP_A: rd_mux = grp_a_reg;
      `TAC_OFS_GRP_B: rd_mux = grp_b_reg;
      `TAC_OFS_MTX_LINES: rd_mux = mtx_lines_reg;
      `TAC_OFS_STATUS: begin
        rd_mux[`TAC_ST_BUSY_BIT] = (state_reg != ST_IDLE);
        rd_mux[`TAC_ST_BREQ_BIT] = breq_reg; // see [R8]
        rd_mux[`TAC_ST_READY_BIT] = ready_reg; // see [R17]
        rd_mux[`TAC_ST_DONE_BIT] = (state_reg == ST_IDLE);
      end
      `TAC_OFS_IRQ_STS: rd_mux = {29'h0, irq_sts_reg};
      `TAC_OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_reg};
      `TAC_OFS_ACQ_SEL: rd_mux = {30'h0, sel_reg}; // see [R2]
      `TAC_OFS_ACQUIRED_COUNT: rd_mux = acquired_count_reg;
      `TAC_OFS_DISCH: rd_mux = disch_reg;
      `TAC_OFS_SPREAD: rd_mux = {24'h0, dev_reg};
      `TAC_OFS_PAD_A: rd_mux = {15'h0, pad_a_res_o};
      `TAC_OFS_PAD_B: rd_mux = {15'h0, pad_b_res_o};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= `TAC_RST_WORD;
    end else if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o <= rd_mux;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      grp_a_reg <= `TAC_RST_WORD;
      grp_b_reg <= `TAC_RST_WORD;
      mtx_lines_reg <= `TAC_RST_WORD;
      sel_reg <= 2'h0;
      disch_reg <= `TAC_RST_WORD;
      dev_reg <= 8'h00;
      pad_a_res_o <= 17'h00000;
      pad_b_res_o <= 17'h00000;
      irq_mask_reg <= 3'h0;
    end else if (wr_acc) begin
      case (avs_address_i)
        `TAC_OFS_GRP_A:
          grp_a_reg <= (grp_a_reg & ~wmask) | (avs_writedata_i & wmask);
        `TAC_OFS_GRP_B:
          grp_b_reg <= (grp_b_reg & ~wmask) | (avs_writedata_i & wmask);
        `TAC_OFS_MTX_LINES:
          mtx_lines_reg <= (mtx_lines_reg & ~wmask) |
                           (avs_writedata_i & wmask);
        `TAC_OFS_ACQ_SEL: sel_reg <= avs_writedata_i[1:0]; // see [R2]
        `TAC_OFS_DISCH:
          disch_reg <= (disch_reg & ~wmask) | (avs_writedata_i & wmask);
        `TAC_OFS_SPREAD:
          if (avs_byteenable_i[0]) begin
            dev_reg <= avs_writedata_i[7:0]; // see [R14]
          end
        `TAC_OFS_PAD_A:
          pad_a_res_o <= avs_writedata_i[16:0]; // see [R15]
        `TAC_OFS_PAD_B:
          pad_b_res_o <= avs_writedata_i[16:0]; // see [R16]
        `TAC_OFS_IRQ_MASK: irq_mask_reg <= avs_writedata_i[2:0];
        default: grp_a_reg <= grp_a_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Analog-side control outputs
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      module_en_o <= 1'b0;
      ref_res_sel_o <= 1'b0;
      ref_volt_sel_o <= 1'b0;
      trim_o <= 5'h00;
      spread_dev_o <= 8'h00;
    end else begin
      module_en_o <= disch_reg[`TAC_DIS_CURRENT_MODULE_ENABLE_BIT]; // see [R11]
      ref_res_sel_o <= disch_reg[`TAC_DIS_RREF_BIT]; // see [R12]
      ref_volt_sel_o <= disch_reg[`TAC_DIS_VREF_BIT]; // see [R12]
      trim_o <= disch_reg[`TAC_DIS_TRIM_LSB +: `TAC_DIS_TRIM_W]; // see [R13]
      spread_dev_o <= dev_reg; // see [R14]
    end
  end

  tac_disch #(.NSRC(8)) u_disch (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .current_module_enable_i(disch_reg[`TAC_DIS_CURRENT_MODULE_ENABLE_BIT]),
    .force_i(disch_reg[`TAC_DIS_FORCE_LSB +: 8]),
    .norm_i(disch_reg[`TAC_DIS_SRC_LSB +: 8]),
    .active_i(state_reg == ST_WAIT_FE),
    .src_en_o(src_en_o)
  );

  // ----------------------------------------------------------------
  // Acquisition sequencer
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      xcur_reg <= 8'h00;
      ycur_reg <= 8'h00;
      yord_reg <= 5'h00;
      fill_reg <= 5'h00;
      breq_reg <= 1'b0;
      fe_start_o <= 1'b0;
      fe_matrix_o <= 1'b0;
      fe_x_o <= 8'h00;
      fe_y_o <= 8'h00;
      fe_burst_o <= 8'h00;
    end else begin
      fe_start_o <= 1'b0;
      if (wr_sel) begin
        // Code 11 is undefined; it is treated as no acquisition
        state_reg <= (avs_writedata_i[1:0] == 2'h3) ? ST_IDLE
                                                    : ST_XFIND; // see [R1]
        xcur_reg <= 8'h00;
        breq_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: state_reg <= ST_IDLE;
          ST_XFIND: begin
            if (!xa_found) begin
              state_reg <= ST_DONE;
            end else begin
              xcur_reg <= xa_idx; // see [R4] [R5]
              ycur_reg <= 8'h00;
              yord_reg <= 5'h00;
              fill_reg <= 5'h00;
              if (!is_matrix) begin
                fe_y_o <= 8'h00; // see [R4]
                fe_burst_o <= 8'h00;
                state_reg <= ST_LAUNCH;
              end else if (ny_cnt != 5'h00) begin
                breq_reg <= 1'b1; // see [R8]
                state_reg <= ST_BURST;
              end else begin
                state_reg <= ST_YFIND;
              end
            end
          end
          ST_BURST: begin
            if (wr_matrix_burst_length) begin
              fill_reg <= fill_reg + 5'h04;
              if ({1'b0, fill_reg} + 6'h04 >= {1'b0, ny_cnt}) begin
                breq_reg <= 1'b0; // see [R18] [R7]
                state_reg <= ST_YFIND;
              end
            end
          end
          ST_YFIND: begin
            if (y_found) begin
              fe_y_o <= y_idx; // see [R5]
              fe_burst_o <= burst_mem[yord_reg[3:0]]; // see [R6]
              state_reg <= ST_LAUNCH;
            end else begin
              xcur_reg <= xcur_reg + 8'h01; // see [R5]
              state_reg <= ST_XFIND;
            end
          end
          ST_LAUNCH: begin
            fe_start_o <= 1'b1;
            fe_matrix_o <= is_matrix;
            fe_x_o <= xcur_reg;
            state_reg <= ST_WAIT_FE;
          end
          ST_WAIT_FE: begin
            if (fe_done_i) begin
              state_reg <= ST_WAIT_RD;
            end
          end
          ST_WAIT_RD: begin
            // The next channel waits until software took the word
            if (!ready_reg) begin
              if (is_matrix) begin
                ycur_reg <= fe_y_o + 8'h01; // see [R5]
                yord_reg <= yord_reg + 5'h01;
                state_reg <= ST_YFIND;
              end else begin
                xcur_reg <= xcur_reg + 8'h01; // see [R4]
                state_reg <= ST_XFIND;
              end
            end
          end
          ST_DONE: state_reg <= ST_IDLE;
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Burst fields land on successive enabled Y values, first field first
  always @(posedge ref_clk_i) begin
    if (wr_matrix_burst_length && state_reg == ST_BURST) begin
      for (k = 0; k < 4; k = k + 1) begin
        if (fill_reg + k < NY) begin
          burst_mem[fill_reg[3:0] + k[3:0]] <=
            avs_writedata_i[31 - 8 * k -: 8]; // see [R18] [R6]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Count word and ready flag
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acquired_count_reg <= `TAC_RST_WORD;
      ready_reg <= 1'b0;
    end else begin
      if (new_count) begin
        acquired_count_reg[`TAC_CNT_LSB +: 16] <= fe_count_i; // see [R3]
        acquired_count_reg[`TAC_IDX_X_LSB +: 8] <= fe_x_o; // see [R3]
        acquired_count_reg[`TAC_IDX_Y_LSB +: 8] <= fe_y_o; // see [R3]
      end
      // A word arriving in the read cycle keeps the flag set
      ready_reg <= new_count | (ready_reg & ~rd_count); // see [R17]
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  reg breq_d_reg;
  assign breq_rise = breq_reg & ~breq_d_reg;

  always @* begin
    irq_sts_next = irq_sts_reg;
    if (wr_acc && avs_address_i == `TAC_OFS_IRQ_STS) begin
      irq_sts_next = irq_sts_next & ~avs_writedata_i[2:0];
    end
    irq_sts_next[`TAC_IRQ_READY] = irq_sts_next[`TAC_IRQ_READY] | new_count;
    irq_sts_next[`TAC_IRQ_DONE] = irq_sts_next[`TAC_IRQ_DONE] | acq_done;
    irq_sts_next[`TAC_IRQ_BREQ] = irq_sts_next[`TAC_IRQ_BREQ] | breq_rise;
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_sts_reg <= 3'h0;
      breq_d_reg <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      irq_sts_reg <= irq_sts_next;
      breq_d_reg <= breq_reg;
      irq_o <= |(irq_sts_next & irq_mask_reg);
    end
  end
endmodule // tac_top

// File: core/tac_consts.vh
`ifndef TAC_CONSTS_VH
`define TAC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define TAC_OFS_GRP_A      8'h00
`define TAC_OFS_GRP_B      8'h04
`define TAC_OFS_MTX_LINES  8'h08
`define TAC_OFS_STATUS     8'h3c
`define TAC_OFS_IRQ_STS    8'h40
`define TAC_OFS_IRQ_MASK   8'h44
`define TAC_OFS_ACQ_SEL    8'h50
`define TAC_OFS_ACQUIRED_COUNT     8'h54
`define TAC_OFS_MATRIX_BURST_LENGTH      8'h58
`define TAC_OFS_DISCH      8'h5c
`define TAC_OFS_SPREAD     8'h60
`define TAC_OFS_PAD_A      8'h64
`define TAC_OFS_PAD_B      8'h68

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TAC_RST_WORD       32'h00000000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TAC_SEL_SELF_A     2'h0
`define TAC_SEL_SELF_B     2'h1
`define TAC_SEL_MATRIX     2'h2
`define TAC_CNT_LSB        0
`define TAC_IDX_X_LSB      16
`define TAC_IDX_Y_LSB      24
`define TAC_DIS_FORCE_LSB  24
`define TAC_DIS_CURRENT_MODULE_ENABLE_BIT   23
`define TAC_DIS_VREF_BIT   17
`define TAC_DIS_RREF_BIT   16
`define TAC_DIS_TRIM_LSB   8
`define TAC_DIS_TRIM_W     5
`define TAC_DIS_SRC_LSB    0
`define TAC_DEV_W          8
`define TAC_PAD_W          17
`define TAC_MTX_Y_LSB      16
`define TAC_ST_BREQ_BIT    4
`define TAC_ST_READY_BIT   8
`define TAC_ST_DONE_BIT    9
`define TAC_ST_BUSY_BIT    0
`define TAC_IRQ_READY      0
`define TAC_IRQ_DONE       1
`define TAC_IRQ_BREQ       2
`define TAC_IRQ_W          3

`endif

// File: core/tac_chan_find.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Lowest enabled channel at or above a start index
// ----------------------------------------------------------------
module tac_chan_find #(
  parameter N = 32
) (
  input wire [N-1:0] mask_i,
  input wire [7:0] from_i,
  output reg found_o,
  output reg [7:0] idx_o
);
  wire [N-1:0] cand;
  integer i;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_cand
      assign cand[g] = mask_i[g] & (g >= from_i);
    end
  endgenerate

  always @* begin
    found_o = 1'b0;
    idx_o = 8'h00;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (cand[i]) begin
        found_o = 1'b1;
        idx_o = i[7:0];
      end
    end
  end
endmodule // tac_chan_find

// File: core/tac_disch.v
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Discharge current source enables, one flop per source
// ----------------------------------------------------------------
module tac_disch #(
  parameter NSRC = 8
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire current_module_enable_i,
  input wire [NSRC-1:0] force_i,
  input wire [NSRC-1:0] norm_i,
  input wire active_i,
  output reg [NSRC-1:0] src_en_o
);
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_src
      always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          src_en_o[g] <= 1'b0;
        end else begin
          // Global enable gates all; force overrides normal timing
          src_en_o[g] <= current_module_enable_i & (force_i[g] | (norm_i[g] & active_i)); // see [R9] [R10] [R11]
        end
      end
    end
  endgenerate
endmodule // tac_disch

// File: verification/tac_top_sva.sv
`timescale 1ns/1ps
module tac_top_sva #(
  parameter NPAIR = 32,
  parameter NY = 16
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire fe_start_o,
  input wire [7:0] fe_x_o,
  input wire [7:0] fe_y_o,
  input wire [7:0] src_en_o,
  input wire module_en_o,
  input wire ref_res_sel_o,
  input wire ref_volt_sel_o,
  input wire [4:0] trim_o,
  input wire [7:0] spread_dev_o,
  input wire [16:0] pad_a_res_o,
  input wire [16:0] pad_b_res_o
);
  reg [1:0] sel_q;
  reg [31:0] wr_q;
  wire acc_w = avs_write_i && !avs_waitrequest_o;
  wire acc_r = avs_read_i && !avs_waitrequest_o;
  // ----------------------------------------------------------------
  // Last written values
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_q <= 2'h0;
      wr_q <= 32'h00000000;
    end else if (acc_w) begin
      wr_q <= avs_writedata_i;
      if (avs_address_i == 8'h50)
        sel_q <= avs_writedata_i[1:0];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_wait_one_cycle: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest did not drop after one cycle");
  a_wait_low_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_sel_read_back: assert property (
    acc_r && avs_address_i == 8'h50 |-> avs_readdata_o == {30'h0, sel_q})
    else $error("selection read does not match last write");
  a_pad_a_drive: assert property (
    acc_w && avs_address_i == 8'h64 |=> pad_a_res_o == wr_q[16:0])
    else $error("first side pad bits not applied");
  a_pad_b_drive: assert property (
    acc_w && avs_address_i == 8'h68 |=> pad_b_res_o == wr_q[16:0])
    else $error("second side pad bits not applied");
  a_disch_cfg_copy: assert property (
    acc_w && avs_address_i == 8'h5c && avs_byteenable_i == 4'hf |=> ##1
    {module_en_o, ref_volt_sel_o, ref_res_sel_o, trim_o} ==
    {wr_q[23], wr_q[17], wr_q[16], wr_q[12:8]})
    else $error("discharge configuration outputs wrong");
  a_spread_dev_copy: assert property (
    acc_w && avs_address_i == 8'h60 && avs_byteenable_i[0] |=> ##1
    spread_dev_o == wr_q[7:0])
    else $error("deviation output wrong");
  a_current_module_enable_gates_src: assert property (!module_en_o |-> src_en_o == 8'h00)
    else $error("discharge source on while module disabled");
  a_start_pulse: assert property (fe_start_o |=> !fe_start_o)
    else $error("launch pulse longer than one cycle");
  a_index_hold: assert property (
    fe_start_o |=> ($stable(fe_x_o) && $stable(fe_y_o)) [*3])
    else $error("channel index changed during measurement");
endmodule // tac_top_sva

bind tac_top tac_top_sva #(.NPAIR(NPAIR), .NY(NY)) i_sva (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .fe_start_o(fe_start_o), .fe_x_o(fe_x_o), .fe_y_o(fe_y_o),
  .src_en_o(src_en_o), .module_en_o(module_en_o),
  .ref_res_sel_o(ref_res_sel_o), .ref_volt_sel_o(ref_volt_sel_o),
  .trim_o(trim_o), .spread_dev_o(spread_dev_o),
  .pad_a_res_o(pad_a_res_o), .pad_b_res_o(pad_b_res_o));

// File: verification/tac_fe_model.sv
`timescale 1ns/1ps
module tac_fe_model (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire fe_start_i,
  input wire [7:0] fe_x_i,
  input wire [7:0] fe_y_i,
  input wire [7:0] fe_burst_i,
  input wire [7:0] delay_i,
  output reg fe_done_o,
  output reg [15:0] fe_count_o,
  output reg [7:0] burst_seen_o
);
  reg [7:0] cnt;
  reg busy;
  reg [15:0] val;
  // Count lines toggle outside the done pulse so stale data never matches
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fe_done_o <= 1'b0;
      fe_count_o <= 16'h0000;
      burst_seen_o <= 8'h00;
      busy <= 1'b0;
      cnt <= 8'h00;
      val <= 16'h0000;
    end else begin
      fe_done_o <= 1'b0;
      fe_count_o <= ~fe_count_o;
      if (fe_start_i) begin
        busy <= 1'b1;
        cnt <= delay_i;
        val <= {fe_x_i, fe_y_i} ^ 16'h5a5a;
        burst_seen_o <= fe_burst_i;
      end else if (busy) begin
        if (cnt <= 8'h01) begin
          busy <= 1'b0;
          fe_done_o <= 1'b1;
          fe_count_o <= val;
        end else
          cnt <= cnt - 8'h01;
      end
    end
  end
endmodule // tac_fe_model

// File: verification/touch_acquisition_control_tb_top.sv
`timescale 1ns/1ps
`include "tac_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module touch_acquisition_control_tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_o, irq, fe_start, fe_matrix, fe_done, men, rres, rvolt;
  logic [7:0] fe_x, fe_y, fe_burst, src_en, dev, burst_seen;
  logic [7:0] delay = 8'h0a;
  logic [15:0] fe_count;
  logic [4:0] trim;
  logic [16:0] pad_a, pad_b;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  tac_top i_dut (
    .ref_clk_i(ref_clk), .rstn_i(rstn), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .irq_o(irq), .fe_start_o(fe_start),
    .fe_matrix_o(fe_matrix), .fe_x_o(fe_x), .fe_y_o(fe_y),
    .fe_burst_o(fe_burst), .fe_done_i(fe_done), .fe_count_i(fe_count),
    .src_en_o(src_en), .module_en_o(men), .ref_res_sel_o(rres),
    .ref_volt_sel_o(rvolt), .trim_o(trim), .spread_dev_o(dev),
    .pad_a_res_o(pad_a), .pad_b_res_o(pad_b));
  tac_fe_model i_fe (
    .ref_clk_i(ref_clk), .rstn_i(rstn), .fe_start_i(fe_start),
    .fe_x_i(fe_x), .fe_y_i(fe_y), .fe_burst_i(fe_burst), .delay_i(delay),
    .fe_done_o(fe_done), .fe_count_o(fe_count), .burst_seen_o(burst_seen));
  // ----------------------------------------------------------------
  // Bus access and helpers
  // ----------------------------------------------------------------
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= we;
    rd <= !we;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wait_o !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) mismatches++;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chkreg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic wait_st(input int b, input logic v);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, `TAC_OFS_STATUS, 32'h0, q);
      n++;
    end while (q[b] !== v && n < 100);
    `CHK(q[b], v)
  endtask
  function automatic logic [15:0] exp_cnt(input logic [7:0] x, y);
    return {x, y} ^ 16'h5a5a;
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] ofs[8] = '{8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h64,
                           8'h68, 8'h6c};
    for (int i = 0; i < 8; i++) chkreg(ofs[i], 32'h0);
  endtask
  task automatic t_config;
    wreg(`TAC_OFS_DISCH, 32'h05831f3c);
    chkreg(`TAC_OFS_DISCH, 32'h05831f3c);
    repeat (2) @(posedge ref_clk);
    `CHK({men, rvolt, rres, trim}, 8'hff)
    `CHK(src_en, 8'h05)
    wreg(`TAC_OFS_DISCH, 32'h05031f3c);
    repeat (2) @(posedge ref_clk);
    `CHK(src_en, 8'h00)
    wreg(`TAC_OFS_DISCH, 32'h00820a3c);
    repeat (2) @(posedge ref_clk);
    `CHK({men, rvolt, rres, trim}, {3'b110, 5'h0a})
    `CHK(src_en, 8'h00)
    wreg(`TAC_OFS_SPREAD, 32'hffffffa5);
    chkreg(`TAC_OFS_SPREAD, 32'h000000a5);
    `CHK(dev, 8'ha5)
    wreg(`TAC_OFS_PAD_A, 32'hffffaaaa);
    chkreg(`TAC_OFS_PAD_A, 32'h0001aaaa);
    `CHK(pad_a, 17'h1aaaa)
    wreg(`TAC_OFS_PAD_B, 32'h00015555);
    chkreg(`TAC_OFS_PAD_B, 32'h00015555);
    `CHK(pad_b, 17'h15555)
  endtask
  task automatic t_self(input logic [1:0] code, input logic [7:0] ofs,
                        input logic [31:0] mask);
    int n;
    bit first;
    first = 1;
    wreg(ofs, mask);
    wreg(`TAC_OFS_ACQ_SEL, {30'h0, code});
    for (int i = 0; i < 32; i++) begin
      if (mask[i]) begin
        if (first) begin
          n = 0;
          while (fe_start !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
          end
          repeat (3) @(posedge ref_clk);
          `CHK(src_en, 8'h3c)
          `CHK(fe_matrix, 1'b0)
          first = 0;
        end
        wait_st(`TAC_ST_READY_BIT, 1'b1);
        chkreg(`TAC_OFS_ACQUIRED_COUNT, {8'h0, i[7:0], exp_cnt(i, 8'h0)});
      end
    end
    wait_st(`TAC_ST_DONE_BIT, 1'b1);
    `CHK(src_en, 8'h00)
    wait_st(`TAC_ST_READY_BIT, 1'b0);
    chkreg(`TAC_OFS_ACQ_SEL, {30'h0, code});
  endtask
  task automatic t_irq;
    chkreg(`TAC_OFS_IRQ_STS, 32'h3);
    wreg(`TAC_OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    wreg(`TAC_OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    wreg(`TAC_OFS_IRQ_MASK, 32'h3);
    wreg(`TAC_OFS_IRQ_STS, 32'h3);
    chkreg(`TAC_OFS_IRQ_STS, 32'h0);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_matrix;
    logic [7:0] ys[5] = '{8'h00, 8'h02, 8'h05, 8'h06, 8'h09};
    logic [7:0] bs[5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    delay <= 8'h01;
    wreg(`TAC_OFS_MTX_LINES, 32'h0265000c);
    wreg(`TAC_OFS_ACQ_SEL, 32'h2);
    for (int x = 2; x < 4; x++) begin
      wait_st(`TAC_ST_BREQ_BIT, 1'b1);
      wreg(`TAC_OFS_MATRIX_BURST_LENGTH, 32'h11223344);
      wait_st(`TAC_ST_BREQ_BIT, 1'b1);
      wreg(`TAC_OFS_MATRIX_BURST_LENGTH, 32'h55000000);
      wait_st(`TAC_ST_BREQ_BIT, 1'b0);
      for (int k = 0; k < 5; k++) begin
        wait_st(`TAC_ST_READY_BIT, 1'b1);
        chkreg(`TAC_OFS_ACQUIRED_COUNT, {ys[k], x[7:0], exp_cnt(x, ys[k])});
        `CHK(burst_seen, bs[k])
        `CHK(fe_matrix, 1'b1)
      end
    end
    wait_st(`TAC_ST_DONE_BIT, 1'b1);
    chkreg(`TAC_OFS_ACQ_SEL, 32'h2);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_config();
    t_self(2'h0, `TAC_OFS_GRP_A, 32'h00000212);
    t_self(2'h1, `TAC_OFS_GRP_B, 32'h80000001);
    t_irq();
    t_matrix();
    results();
  end
endmodule // touch_acquisition_control_tb_top
